/* File: fsp_pkg.sv */
/*
 * Shared constants and types of the flash self-program controller.
 * Assumes a 10 MHz core clock and an 8-bit register port with 12-bit addresses.
 */
package fsp_pkg;

	// ********************************************************
	// Register map
	// ********************************************************
	localparam int unsigned REG_ADDR_W        = 12;
	localparam logic [11:0] OFF_FLASH_CONTROL = 12'hfa6;
	localparam logic [11:0] OFF_UNLOCK_KEY    = 12'hfa7;
	localparam logic [11:0] OFF_TABLE_LATCH   = 12'hff5;
	localparam logic [11:0] OFF_PTR_LOW       = 12'hff6;
	localparam logic [11:0] OFF_PTR_HIGH      = 12'hff7;
	localparam logic [11:0] OFF_PTR_UPPER     = 12'hff8;

	// ********************************************************
	// Control register fields
	// ********************************************************
	localparam int unsigned CTL_WORD_PROG = 5;
	localparam int unsigned CTL_ERASE     = 4;
	localparam int unsigned CTL_WRITE_ERROR_FLAG     = 3;
	localparam int unsigned CTL_WRITE_ENABLE_BIT      = 2;
	localparam int unsigned CTL_START     = 1;
	localparam logic [7:0]  KEY_FIRST     = 8'h55;
	localparam logic [7:0]  KEY_SECOND    = 8'haa;

	// ********************************************************
	// Pointer and array geometry
	// ********************************************************
	localparam int unsigned PTR_W        = 22;
	localparam int unsigned PTR_ADDR_W   = 21;
	localparam int unsigned PTR_CFG_BIT  = 21;
	localparam int unsigned HOLD_DEPTH   = 64;
	localparam int unsigned HOLD_IDX_W   = 6;
	localparam int unsigned BLK_LSB      = 10;
	localparam int unsigned BLK_W        = 12;
	localparam int unsigned ROW_LSB      = 6;
	localparam logic [6:0]  ROW_BYTES    = 7'h40;
	localparam logic [6:0]  WORD_BYTES   = 7'h02;
	localparam logic [7:0]  ERASED_BYTE  = 8'hff;
	localparam logic [7:0]  ZERO_BYTE    = 8'h00;

	// ********************************************************
	// Timing
	// ********************************************************
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned TMR_W         = 24;

	typedef enum logic [1:0] {PTR_KEEP, PTR_POST_INC, PTR_POST_DEC, PTR_PRE_INC} fsp_ptr_mode_e;
	typedef enum logic [1:0] {SEQ_IDLE, SEQ_LOAD, SEQ_WAIT} fsp_seq_e;

endpackage

/* File: fsp_hold_if.sv */
/*
 * Link between the sequencer and the program-memory holding registers.
 * Assumes both ends run on the core clock.
 */
interface fsp_hold_if;
	import fsp_pkg::*;

	logic                  wr_en;
	logic [HOLD_IDX_W-1:0] wr_idx;
	logic [7:0]            wr_data;
	logic [HOLD_IDX_W-1:0] rd_idx;
	logic [7:0]            rd_data;
	logic                  fill;

	modport owner (output wr_en, output wr_idx, output wr_data, output rd_idx, output fill, input rd_data);
	modport store (input wr_en, input wr_idx, input wr_data, input rd_idx, input fill, output rd_data);

endinterface

/* File: fsp_hold_buf.sv */
/*
 * Holding registers: 64 bytes of flip-flops filled by table writes.
 * Assumes the owner never writes and fills in the same cycle.
 */
module fsp_hold_buf
	import fsp_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ce,
	fsp_hold_if.store hold
);

	logic [7:0] mem_r [HOLD_DEPTH];

	// ********************************************************
	// One byte per entry
	// ********************************************************
	genvar gi;
	generate
		for (gi = 0; gi < HOLD_DEPTH; gi++)
		begin : g_entry
			always_ff @(posedge clk)
			begin
				if (!rst_n)
					mem_r[gi] <= ERASED_BYTE;
				else if (ce)
				begin
					// Emptied after each program so stale bytes never reach the array
					if (hold.fill)
						mem_r[gi] <= ERASED_BYTE;
					else if (hold.wr_en && hold.wr_idx == HOLD_IDX_W'(gi))
						mem_r[gi] <= hold.wr_data;
				end
			end
		end
	endgenerate

	assign hold.rd_data = mem_r[hold.rd_idx];

endmodule

/* File: fsp_ctrl.sv */
/*
 * Flash self-program controller: table reads and writes, unlock key,
 * control register, holding-register program and block erase sequencer.
 * Assumes a flash array on the same clock that returns a 16-bit word in the
 * cycle after a read enable, and a core that waits for tbl_done.
 */
// The address-and-strobe port was left to the implementer.
//
// Overview of operation
// - A table read fetches one byte into the table latch.
// - Erase always clears a whole 1024-byte block.
// - No command exists that erases the whole program memory.
// - Instruction fetch is stalled while program or erase runs.
// - An internal timer alone sets and ends each operation's length.
// - Bytes move between program memory and data only via the latch.
// - Table write loads a holding register; array changes only on start.
// - Table reads and writes use any byte address, no alignment.
// - The unlock key port stores nothing and reads as zero.
// - Word program select picks 2-byte or 64-byte programming.
// - Erase select makes start erase; hardware clears it on completion.
// - Error flag sets on start, clears on normal timer completion.
// - Error flag stays set across reset mid-operation or improper attempt.
// - Write enable clears on power-up and gates program and erase.
// - Software can only set start; hardware clears it at the end.
// - Control bits 7-6 and 0 ignore writes and read zero.
// - Start is accepted only right after key writes 0x55 then 0xAA.
// - Pointer is 22 bits; top bit selects configuration space.
// - Low pointer bits pick holding register; upper twelve pick the block.
// - Four pointer updates per table op, on the low 21 bits only.
module fsp_ctrl
	import fsp_pkg::*;
#(
	parameter int unsigned PROG_TIME_NS  = 1000000,
	parameter int unsigned ERASE_TIME_NS = 2000000
)
(
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic                  por_n,
	input  wire logic                  ce,
	input  wire logic [REG_ADDR_W-1:0] reg_addr,
	input  wire logic [7:0]            reg_wdata,
	input  wire logic                  reg_we,
	input  wire logic                  reg_re,
	output logic      [7:0]            reg_rdata,
	input  wire logic                  tbl_req,
	input  wire logic                  tbl_write,
	input  wire fsp_ptr_mode_e         tbl_mode,
	output logic                       tbl_done,
	output logic                       fetch_stall,
	output logic                       flash_rd_en,
	output logic      [PTR_W-1:0]      flash_rd_addr,
	input  wire logic [15:0]           flash_rd_data,
	output logic                       flash_wr_en,
	output logic      [PTR_W-1:0]      flash_wr_addr,
	output logic      [7:0]            flash_wr_data,
	output logic                       flash_erase_en,
	output logic      [BLK_W-1:0]      flash_erase_blk
);

	// ********************************************************
	// Timer lengths
	// ********************************************************
	// Least times, rounded up to whole cycles
	localparam int unsigned PROG_CYC  = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned ERASE_CYC = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [TMR_W-1:0] PROG_LOAD_VAL  = TMR_W'(PROG_CYC - 1);
	localparam logic [TMR_W-1:0] ERASE_LOAD_VAL = TMR_W'(ERASE_CYC - 1);

	// ********************************************************
	// Declarations
	// ********************************************************
	logic                  sys_rst_n;
	logic                  word_prog_r;
	logic                  erase_sel_r;
	logic                  write_error_flag_r;
	logic                  write_enable_bit_r;
	logic                  start_r;
	logic                  key_stage_r;
	logic                  armed_r;
	logic [7:0]            table_latch_r;
	logic [PTR_W-1:0]      table_pointer_r;
	logic                  rd_pend_r;
	logic                  rd_cap_r;
	logic                  tbl_done_r;
	fsp_seq_e              seq_r;
	logic                  seq_erase_r;
	logic [TMR_W-1:0]      tmr_r;
	logic [PTR_W-1:0]      seq_addr_r;
	logic [6:0]            seq_cnt_r;
	logic                  fetch_stall_r;
	logic                  flash_rd_en_r;
	logic [PTR_W-1:0]      flash_rd_addr_r;
	logic                  flash_wr_en_r;
	logic [PTR_W-1:0]      flash_wr_addr_r;
	logic [7:0]            flash_wr_data_r;
	logic                  flash_erase_en_r;
	logic [BLK_W-1:0]      flash_erase_blk_r;
	logic [7:0]            reg_rdata_r;
	logic                  ctl_wr;
	logic                  key_wr;
	logic                  start_req;
	logic                  start_go;
	logic                  start_bad;
	logic                  seq_done;
	logic                  tbl_busy;
	logic                  tbl_take;
	logic [PTR_ADDR_W-1:0] ptr_low;
	logic [PTR_ADDR_W-1:0] ptr_eff;
	logic [PTR_ADDR_W-1:0] ptr_nxt;

	fsp_hold_if hold ();

	fsp_hold_buf u_hold (
		.clk   (clk),
		.rst_n (sys_rst_n),
		.ce    (ce),
		.hold  (hold)
	);

	// ********************************************************
	// Decode
	// ********************************************************
	assign sys_rst_n = rst_n & por_n;
	assign ctl_wr    = reg_we && reg_addr == OFF_FLASH_CONTROL;
	assign key_wr    = reg_we && reg_addr == OFF_UNLOCK_KEY;
	assign start_req = ctl_wr && reg_wdata[CTL_START] && !start_r;
	assign start_go  = start_req && reg_wdata[CTL_WRITE_ENABLE_BIT] && armed_r;
	assign start_bad = start_req && !(reg_wdata[CTL_WRITE_ENABLE_BIT] && armed_r);
	assign seq_done  = seq_r == SEQ_WAIT && tmr_r == '0;
	assign tbl_busy  = rd_pend_r || rd_cap_r || seq_r != SEQ_IDLE;
	assign tbl_take  = tbl_req && !tbl_busy;

	// Pointer arithmetic touches only the byte address, never the space bit
	assign ptr_low = table_pointer_r[PTR_ADDR_W-1:0];
	assign ptr_eff = (tbl_mode == PTR_PRE_INC) ? ptr_low + 1'b1 : ptr_low;
	always_comb
	begin
		unique case (tbl_mode)
			PTR_KEEP:     ptr_nxt = ptr_low;
			PTR_POST_INC: ptr_nxt = ptr_low + 1'b1;
			PTR_POST_DEC: ptr_nxt = ptr_low - 1'b1;
			PTR_PRE_INC:  ptr_nxt = ptr_low + 1'b1;
		endcase
	end

	// Table write lands in a holding register only
	assign hold.wr_en   = ce && tbl_take && tbl_write;
	assign hold.wr_idx  = ptr_eff[HOLD_IDX_W-1:0];
	assign hold.wr_data = table_latch_r;
	assign hold.rd_idx  = seq_addr_r[HOLD_IDX_W-1:0];
	assign hold.fill    = ce && seq_done && !seq_erase_r;

	// ********************************************************
	// Control register
	// ********************************************************
	always_ff @(posedge clk)
	begin
		if (!sys_rst_n)
		begin
			word_prog_r <= 1'b0;
			erase_sel_r <= 1'b0;
			write_enable_bit_r      <= 1'b0;
			start_r     <= 1'b0;
		end
		else if (ce)
		begin
			if (ctl_wr)
			begin
				word_prog_r <= reg_wdata[CTL_WORD_PROG];
				erase_sel_r <= reg_wdata[CTL_ERASE];
				write_enable_bit_r      <= reg_wdata[CTL_WRITE_ENABLE_BIT];
			end
			// Zero written to start is simply dropped
			if (start_go)
				start_r <= 1'b1;
			if (seq_done)
			begin
				start_r <= 1'b0;
				if (seq_erase_r)
					erase_sel_r <= 1'b0;
			end
		end
	end

	// Of the two resets only por_n clears the error flag, so an op cut off by rst_n stays flagged
	always_ff @(posedge clk)
	begin
		if (!por_n)
			write_error_flag_r <= 1'b0;
		else if (ce)
		begin
			if (ctl_wr)
				write_error_flag_r <= reg_wdata[CTL_WRITE_ERROR_FLAG];
			if (seq_done)
				write_error_flag_r <= 1'b0;
			if (start_go || start_bad)
				write_error_flag_r <= 1'b1;
		end
	end

	// ********************************************************
	// Unlock key
	// ********************************************************
	// Any other register write breaks the sequence
	always_ff @(posedge clk)
	begin
		if (!sys_rst_n)
		begin
			key_stage_r <= 1'b0;
			armed_r     <= 1'b0;
		end
		else if (ce && reg_we)
		begin
			if (key_wr)
			begin
				key_stage_r <= reg_wdata == KEY_FIRST;
				armed_r     <= key_stage_r && reg_wdata == KEY_SECOND;
			end
			else
			begin
				key_stage_r <= 1'b0;
				armed_r     <= 1'b0;
			end
		end
	end

	// ********************************************************
	// Table pointer and latch
	// ********************************************************
	always_ff @(posedge clk)
	begin
		if (!sys_rst_n)
			table_pointer_r <= '0;
		else if (ce)
		begin
			if (reg_we && reg_addr == OFF_PTR_LOW)
				table_pointer_r[7:0] <= reg_wdata;
			if (reg_we && reg_addr == OFF_PTR_HIGH)
				table_pointer_r[15:8] <= reg_wdata;
			if (reg_we && reg_addr == OFF_PTR_UPPER)
				table_pointer_r[PTR_W-1:16] <= reg_wdata[PTR_W-17:0];
			if (tbl_take)
				table_pointer_r[PTR_ADDR_W-1:0] <= ptr_nxt;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!sys_rst_n)
			table_latch_r <= ZERO_BYTE;
		else if (ce)
		begin
			if (reg_we && reg_addr == OFF_TABLE_LATCH)
				table_latch_r <= reg_wdata;
			// Address bit 0 picks the byte of the word
			if (rd_cap_r)
				table_latch_r <= flash_rd_addr_r[0] ? flash_rd_data[15:8] : flash_rd_data[7:0];
		end
	end

	// ********************************************************
	// Table operation pipeline
	// ********************************************************
	always_ff @(posedge clk)
	begin
		if (!sys_rst_n)
		begin
			rd_pend_r       <= 1'b0;
			rd_cap_r        <= 1'b0;
			tbl_done_r      <= 1'b0;
			flash_rd_en_r   <= 1'b0;
			flash_rd_addr_r <= '0;
		end
		else if (ce)
		begin
			rd_pend_r     <= tbl_take && !tbl_write;
			rd_cap_r      <= rd_pend_r;
			flash_rd_en_r <= tbl_take && !tbl_write;
			tbl_done_r    <= (tbl_take && tbl_write) || rd_cap_r;
			if (tbl_take && !tbl_write)
				flash_rd_addr_r <= {table_pointer_r[PTR_CFG_BIT], ptr_eff};
		end
	end

	// ********************************************************
	// Program and erase sequencer
	// ********************************************************
	always_ff @(posedge clk)
	begin
		if (!sys_rst_n)
		begin
			seq_r       <= SEQ_IDLE;
			seq_erase_r <= 1'b0;
			tmr_r       <= '0;
			seq_addr_r  <= '0;
			seq_cnt_r   <= '0;
		end
		else if (ce)
		begin
			if (seq_r != SEQ_IDLE && tmr_r != '0)
				tmr_r <= tmr_r - 1'b1;
			unique case (seq_r)
				SEQ_IDLE:
				begin
					if (start_go)
					begin
						seq_erase_r <= reg_wdata[CTL_ERASE];
						if (reg_wdata[CTL_ERASE])
						begin
							tmr_r <= ERASE_LOAD_VAL;
							seq_r <= SEQ_WAIT;
						end
						else
						begin
							tmr_r <= PROG_LOAD_VAL;
							seq_r <= SEQ_LOAD;
							// Word mode takes the aligned byte pair, row mode the whole row
							if (reg_wdata[CTL_WORD_PROG])
							begin
								seq_addr_r <= {table_pointer_r[PTR_W-1:1], 1'b0};
								seq_cnt_r  <= WORD_BYTES;
							end
							else
							begin
								seq_addr_r <= {table_pointer_r[PTR_W-1:ROW_LSB], {ROW_LSB{1'b0}}};
								seq_cnt_r  <= ROW_BYTES;
							end
						end
					end
				end
				SEQ_LOAD:
				begin
					seq_addr_r <= seq_addr_r + 1'b1;
					seq_cnt_r  <= seq_cnt_r - 1'b1;
					if (seq_cnt_r == 7'h01)
						seq_r <= SEQ_WAIT;
				end
				SEQ_WAIT:
				begin
					if (seq_done)
						seq_r <= SEQ_IDLE;
				end
			endcase
		end
	end

	// ********************************************************
	// Array strobes and fetch stall
	// ********************************************************
	always_ff @(posedge clk)
	begin
		if (!sys_rst_n)
		begin
			flash_wr_en_r     <= 1'b0;
			flash_wr_addr_r   <= '0;
			flash_wr_data_r   <= ZERO_BYTE;
			flash_erase_en_r  <= 1'b0;
			flash_erase_blk_r <= '0;
			fetch_stall_r     <= 1'b0;
		end
		else if (ce)
		begin
			flash_wr_en_r    <= seq_r == SEQ_LOAD;
			flash_erase_en_r <= start_go && reg_wdata[CTL_ERASE];
			if (seq_r == SEQ_LOAD)
			begin
				flash_wr_addr_r <= seq_addr_r;
				flash_wr_data_r <= hold.rd_data;
			end
			// Only a block number leaves, so nothing larger can be erased
			if (start_go)
				flash_erase_blk_r <= table_pointer_r[PTR_W-1:BLK_LSB];
			if (start_go)
				fetch_stall_r <= 1'b1;
			else if (seq_done)
				fetch_stall_r <= 1'b0;
		end
	end

	// ********************************************************
	// Register read port
	// ********************************************************
	always_ff @(posedge clk)
	begin
		if (!sys_rst_n)
			reg_rdata_r <= ZERO_BYTE;
		else if (ce)
		begin
			reg_rdata_r <= ZERO_BYTE;
			if (reg_re)
			begin
				unique case (reg_addr)
					OFF_FLASH_CONTROL: reg_rdata_r <= {2'b00, word_prog_r, erase_sel_r, write_error_flag_r,
						write_enable_bit_r, start_r, 1'b0};
					OFF_TABLE_LATCH:   reg_rdata_r <= table_latch_r;
					OFF_PTR_LOW:       reg_rdata_r <= table_pointer_r[7:0];
					OFF_PTR_HIGH:      reg_rdata_r <= table_pointer_r[15:8];
					OFF_PTR_UPPER:     reg_rdata_r <= {2'b00, table_pointer_r[PTR_W-1:16]};
					// Key port and unmapped addresses read zero
					default:           reg_rdata_r <= ZERO_BYTE;
				endcase
			end
		end
	end

	assign reg_rdata       = reg_rdata_r;
	assign tbl_done        = tbl_done_r;
	assign fetch_stall     = fetch_stall_r;
	assign flash_rd_en     = flash_rd_en_r;
	assign flash_rd_addr   = flash_rd_addr_r;
	assign flash_wr_en     = flash_wr_en_r;
	assign flash_wr_addr   = flash_wr_addr_r;
	assign flash_wr_data   = flash_wr_data_r;
	assign flash_erase_en  = flash_erase_en_r;
	assign flash_erase_blk = flash_erase_blk_r;

endmodule

/* File: fsp_ctrl_assertions.sv */
/*
 * Port checker for fsp_ctrl, bound to every instance.
 * Assumes ce held high and a single core clock.
 */
module fsp_ctrl_checker
	import fsp_pkg::*;
#(
	parameter int unsigned PROG_TIME_NS  = 1000000,
	parameter int unsigned ERASE_TIME_NS = 2000000
)
(
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        por_n,
	input wire logic [11:0] reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_we,
	input wire logic        reg_re,
	input wire logic [7:0]  reg_rdata,
	input wire logic        tbl_done,
	input wire logic        fetch_stall,
	input wire logic        flash_rd_en,
	input wire logic        flash_wr_en,
	input wire logic [21:0] flash_wr_addr,
	input wire logic        flash_erase_en
);
	localparam int PC = (PROG_TIME_NS + 99) / 100;
	localparam int EC = (ERASE_TIME_NS + 99) / 100;
	logic        k1_r;
	logic        k2_r;
	logic        ers_r;
	logic        wp_r;
	logic [15:0] scnt_r;
	logic [15:0] wcnt_r;

	// ****************************************
	// Helpers
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (!rst_n || !por_n)
		begin
			k1_r <= 1'b0;
			k2_r <= 1'b0;
		end
		else if (reg_we)
		begin
			k1_r <= reg_addr == OFF_UNLOCK_KEY && reg_wdata == KEY_FIRST;
			k2_r <= k1_r && reg_addr == OFF_UNLOCK_KEY && reg_wdata == KEY_SECOND;
		end
	end

	// Mode captured from the last idle control write, i.e. the start itself
	always_ff @(posedge clk)
	begin
		if (!rst_n || !por_n)
		begin
			ers_r  <= 1'b0;
			wp_r   <= 1'b0;
			scnt_r <= 16'h0000;
			wcnt_r <= 16'h0000;
		end
		else
		begin
			if (reg_we && reg_addr == OFF_FLASH_CONTROL && !fetch_stall)
			begin
				ers_r <= reg_wdata[CTL_ERASE];
				wp_r  <= reg_wdata[CTL_WORD_PROG];
			end
			scnt_r <= fetch_stall ? scnt_r + 16'h0001 : 16'h0000;
			wcnt_r <= fetch_stall ? wcnt_r + {15'h0000, flash_wr_en} : 16'h0000;
		end
	end

	// ****************************************
	// Properties
	// ****************************************
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n || !por_n);

	sequence s_ctl_wr;
		reg_we && reg_addr == OFF_FLASH_CONTROL;
	endsequence
	sequence s_ctl_rd;
		reg_re && reg_addr == OFF_FLASH_CONTROL;
	endsequence
	sequence s_done2;
		##1 !tbl_done ##1 tbl_done;
	endsequence

	key_read_zero_a: assert property (reg_re && reg_addr == OFF_UNLOCK_KEY |=> reg_rdata == ZERO_BYTE)
		else $error("unlock key port read not zero");
	ctl_unimpl_a: assert property (s_ctl_rd |=> reg_rdata[7:6] == 2'b00 && !reg_rdata[0])
		else $error("unimplemented control bits read nonzero");
	read_walk_a: assert property (flash_rd_en |-> s_done2)
		else $error("table read not done two cycles after array read");
	wr_in_stall_a: assert property (flash_wr_en || flash_erase_en |-> fetch_stall)
		else $error("array changed without stalled fetch");
	start_gate_a: assert property (s_ctl_wr ##0 (reg_wdata[CTL_START] && !fetch_stall)
		|=> fetch_stall == $past(reg_wdata[CTL_WRITE_ENABLE_BIT] && k2_r))
		else $error("start acceptance wrong for enable and key state");
	timer_len_a: assert property ($fell(fetch_stall) |-> scnt_r == (ers_r ? EC : PC))
		else $error("operation length differs from timer setting");
	prog_bytes_a: assert property ($fell(fetch_stall) && !ers_r |-> wcnt_r == (wp_r ? 2 : 64))
		else $error("programmed byte count wrong");
	wr_addr_step_a: assert property (flash_wr_en && $past(flash_wr_en)
		|-> flash_wr_addr == $past(flash_wr_addr) + 22'h1)
		else $error("program bytes not consecutive");
	erase_pulse_a: assert property (flash_erase_en |=> !flash_erase_en [*8])
		else $error("more than one erase pulse");
endmodule

bind fsp_ctrl fsp_ctrl_checker #(.PROG_TIME_NS(PROG_TIME_NS), .ERASE_TIME_NS(ERASE_TIME_NS)) u_chk (.clk, .rst_n,
	.por_n, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata, .tbl_done, .fetch_stall, .flash_rd_en,
	.flash_wr_en, .flash_wr_addr, .flash_erase_en);

/* File: fsp_flash_model.sv */
/*
 * Behavioural flash array, 2 KiB mirrored over the address space.
 * Assumes the controller clock; word read answers the cycle after enable.
 */
module fsp_flash_model
	import fsp_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rd_en,
	input  wire logic [21:0] rd_addr,
	output logic      [15:0] rd_data,
	input  wire logic        wr_en,
	input  wire logic [21:0] wr_addr,
	input  wire logic [7:0]  wr_data,
	input  wire logic        erase_en,
	input  wire logic [11:0] erase_blk
);
	logic [7:0] mem [2048];

	initial
	begin
		foreach (mem[i]) mem[i] = i[7:0] ^ 8'h5a;
		rd_data = 16'h0000;
	end

	// Outside a read the bus toggles so stale data never looks valid
	always @(posedge clk)
	begin
		rd_data <= rd_en ? {mem[{rd_addr[10:1], 1'b1}], mem[{rd_addr[10:1], 1'b0}]} : ~rd_data;
		if (wr_en)
			mem[wr_addr[10:0]] <= wr_data;
		if (erase_en)
			for (int i = 0; i < 1024; i++) mem[{erase_blk[0], i[9:0]}] <= ERASED_BYTE;
	end
endmodule

/* File: tb.sv */
/*
 * Self-checking bench for fsp_ctrl with the flash array model.
 * Assumes shortened timer parameters: 100 program and 50 erase cycles.
 */
module tb
	import fsp_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct {logic [7:0] e; logic [7:0] m; logic [11:0] a;} fsp_exp_s;
	logic          clk = 0, rst_n = 0, por_n = 0, reg_we = 0, reg_re = 0, tbl_req = 0, tbl_write = 0, re_d = 0;
	logic [11:0]   reg_addr = 12'h000;
	logic [7:0]    reg_wdata = 8'h00, reg_rdata, flash_wr_data, lat;
	fsp_ptr_mode_e tbl_mode = PTR_KEEP;
	logic          tbl_done, fetch_stall, flash_rd_en, flash_wr_en, flash_erase_en;
	logic [21:0]   flash_rd_addr, flash_wr_addr, p;
	logic [15:0]   flash_rd_data;
	logic [11:0]   flash_erase_blk;
	logic [7:0]    img [2048];
	logic [7:0]    hold [64];
	fsp_exp_s      q [$];
	fsp_exp_s      x;
	int            errors = 0, comparisons = 0;

	always #50 clk = ~clk;

	fsp_ctrl #(.PROG_TIME_NS(10000), .ERASE_TIME_NS(5000)) dut (.clk, .rst_n, .por_n, .ce(1'b1), .reg_addr,
		.reg_wdata, .reg_we, .reg_re, .reg_rdata, .tbl_req, .tbl_write, .tbl_mode, .tbl_done, .fetch_stall,
		.flash_rd_en, .flash_rd_addr, .flash_rd_data, .flash_wr_en, .flash_wr_addr, .flash_wr_data,
		.flash_erase_en, .flash_erase_blk);
	fsp_flash_model u_flash (.clk, .rd_en(flash_rd_en), .rd_addr(flash_rd_addr), .rd_data(flash_rd_data),
		.wr_en(flash_wr_en), .wr_addr(flash_wr_addr), .wr_data(flash_wr_data), .erase_en(flash_erase_en),
		.erase_blk(flash_erase_blk));

	// ****************************************
	// Checking
	// ****************************************
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e)
		begin
			errors++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask

	always @(posedge clk)
	begin
		re_d <= reg_re;
		if (re_d)
		begin
			x = q.pop_front();
			chk($sformatf("reg_rdata@%h", x.a), x.e & x.m, reg_rdata & x.m);
		end
	end

	task give_verdict;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ****************************************
	// Drivers, all entered just after an edge
	// ****************************************
	task bus(input logic w, input logic [11:0] a, input logic [7:0] d);
		reg_we <= w;
		reg_re <= !w;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
	endtask
	task wr(input logic [11:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask
	task rd(input logic [11:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
		q.push_back('{e, m, a});
		bus(1'b0, a, 8'h00);
	endtask
	task quiet;
		reg_we <= 1'b0;
		reg_re <= 1'b0;
		@(posedge clk);
	endtask
	task setp(input logic [21:0] a);
		p = a;
		wr(OFF_PTR_UPPER, {2'b00, a[21:16]});
		wr(OFF_PTR_HIGH, a[15:8]);
		wr(OFF_PTR_LOW, a[7:0]);
		quiet;
	endtask

	task tbl(input logic w, input fsp_ptr_mode_e m);
		logic [21:0] e;
		int          n;
		e = p;
		n = 0;
		if (m == PTR_PRE_INC)
			e[20:0] = p[20:0] + 21'h1;
		if (w)
			hold[e[5:0]] = lat;
		else
			lat = img[e[10:0]];
		p[20:0] = m == PTR_POST_INC ? p[20:0] + 21'h1 : m == PTR_POST_DEC ? p[20:0] - 21'h1 : e[20:0];
		tbl_req <= 1'b1;
		tbl_write <= w;
		tbl_mode <= m;
		@(posedge clk);
		tbl_req <= 1'b0;
		while (tbl_done !== 1'b1 && n < 8)
		begin
			@(posedge clk);
			n++;
		end
		chk("tbl_done", 8'h01, {7'h00, tbl_done});
		if (!w)
		begin
			rd(OFF_TABLE_LATCH, lat);
			quiet;
		end
	endtask
	task tw(input fsp_ptr_mode_e m);
		lat = 8'($urandom);
		wr(OFF_TABLE_LATCH, lat);
		quiet;
		tbl(1'b1, m);
	endtask

	// Key use: 0 none, 1 proper, 2 broken by a write in between
	task start(input logic [7:0] c, input int k);
		logic [21:0] b;
		int          n;
		n = 0;
		if (k > 0)
			wr(OFF_UNLOCK_KEY, KEY_FIRST);
		if (k == 2)
			wr(OFF_PTR_LOW, p[7:0]);
		if (k > 0)
			wr(OFF_UNLOCK_KEY, KEY_SECOND);
		wr(OFF_FLASH_CONTROL, c);
		quiet;
		chk("fetch_stall", {7'h00, k == 1 && c[2]}, {7'h00, fetch_stall});
		if (k != 1 || !c[2])
		begin
			rd(OFF_FLASH_CONTROL, c & 8'h34 | 8'h08);
			quiet;
			return;
		end
		rd(OFF_FLASH_CONTROL, c | 8'h0a);
		wr(OFF_FLASH_CONTROL, c & 8'hfd | 8'h08);
		rd(OFF_FLASH_CONTROL, c | 8'h0a);
		quiet;
		while (fetch_stall !== 1'b0 && n < 300)
		begin
			@(posedge clk);
			n++;
		end
		chk("fetch_stall", 8'h00, {7'h00, fetch_stall});
		b = c[CTL_WORD_PROG] ? {p[21:1], 1'b0} : {p[21:6], 6'h00};
		if (c[CTL_ERASE])
			for (int i = 0; i < 1024; i++) img[{p[10], i[9:0]}] = ERASED_BYTE;
		else
		begin
			for (int i = 0; i < (c[CTL_WORD_PROG] ? 2 : 64); i++) img[b[10:0] + i] = hold[b[5:0] + i];
			foreach (hold[i]) hold[i] = ERASED_BYTE;
		end
		rd(OFF_FLASH_CONTROL, c & 8'he5);
		quiet;
	endtask

	// ****************************************
	// Tests
	// ****************************************
	initial
	begin
		// Roughly thirty times the expected run
		#2000000;
		errors++;
		give_verdict;
	end

	initial
	begin
		foreach (img[i]) img[i] = i[7:0] ^ 8'h5a;
		foreach (hold[i]) hold[i] = ERASED_BYTE;
		void'($urandom(32'h309a));
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		por_n <= 1'b1;
		@(posedge clk);
		rd(OFF_FLASH_CONTROL, 8'h00);
		wr(OFF_UNLOCK_KEY, 8'h33);
		rd(OFF_UNLOCK_KEY, 8'h00);
		wr(OFF_FLASH_CONTROL, 8'hc1);
		rd(OFF_FLASH_CONTROL, 8'h00);
		rd(12'h100, 8'h00);
		quiet;
		$display("test regs done");
		setp(22'h100 + 22'($urandom_range(255)));
		for (int m = 0; m < 4; m++) tbl(1'b0, fsp_ptr_mode_e'(m));
		rd(OFF_PTR_LOW, p[7:0]);
		rd(OFF_PTR_HIGH, p[15:8]);
		setp(22'h3fffff);
		tbl(1'b0, PTR_POST_INC);
		rd(OFF_PTR_UPPER, 8'h20);
		rd(OFF_PTR_LOW, 8'h00);
		quiet;
		$display("test read done");
		setp(22'h200);
		tw(PTR_POST_INC);
		tw(PTR_KEEP);
		setp(22'h200);
		tbl(1'b0, PTR_POST_INC);
		start(8'h26, 1);
		setp(22'h200);
		repeat (3) tbl(1'b0, PTR_POST_INC);
		$display("test word done");
		setp(22'h43f);
		repeat (3) tw(PTR_POST_DEC);
		start(8'h06, 1);
		setp(22'h43c);
		repeat (5) tbl(1'b0, PTR_POST_INC);
		$display("test row done");
		setp(22'h555);
		start(8'h16, 1);
		setp(22'h3ff);
		repeat (2) tbl(1'b0, PTR_POST_INC);
		$display("test erase done");
		start(8'h06, 0);
		start(8'h02, 1);
		start(8'h06, 2);
		$display("test refuse done");
		setp(22'h500);
		wr(OFF_UNLOCK_KEY, KEY_FIRST);
		wr(OFF_UNLOCK_KEY, KEY_SECOND);
		wr(OFF_FLASH_CONTROL, 8'h26);
		quiet;
		repeat (5) @(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk("fetch_stall", 8'h00, {7'h00, fetch_stall});
		rd(OFF_FLASH_CONTROL, 8'h08, 8'h0a);
		quiet;
		setp(22'h500);
		start(8'h26, 1);
		$display("test reset done");
		repeat (4) @(posedge clk);
		give_verdict;
	end
endmodule
